// ===== rtl/mafa_pkg.sv
// Package: constants and types of the monitor converter and fault alarm block
package mafa_pkg;

	// Two-wire target address
	localparam logic [6:0] TARGET_ADDR      = 7'h36;

	// Register offsets
	localparam logic [7:0] ADDR_PROJ_CTRL   = 8'h0B;
	localparam logic [7:0] ADDR_EMIT_CTRL   = 8'h1B;
	localparam logic [7:0] ADDR_TEMP_HI     = 8'h49;
	localparam logic [7:0] ADDR_TEMP_LO     = 8'h4A;
	localparam logic [7:0] ADDR_COLOUR_HI   = 8'h4B;
	localparam logic [7:0] ADDR_COLOUR_END  = 8'h50;
	localparam logic [7:0] ADDR_BATT_LO     = 8'h51;
	localparam logic [7:0] ADDR_OUT_LO      = 8'h52;
	localparam logic [7:0] ADDR_INPUT_CFG   = 8'h60;
	localparam logic [7:0] ADDR_CONT_CTRL   = 8'h61;
	localparam logic [7:0] ADDR_CONV_STATUS = 8'h62;
	localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h63;
	localparam logic [7:0] ADDR_PIN_CFG     = 8'h64;
	localparam logic [7:0] ADDR_STATUS0     = 8'h70;
	localparam logic [7:0] ADDR_STATUS1     = 8'h71;
	localparam logic [7:0] ADDR_MASK0       = 8'h72;
	localparam logic [7:0] ADDR_MASK1       = 8'h73;
	localparam logic [7:0] ADDR_THRESH      = 8'h74;

	// Field positions
	localparam int ENABLE_BIT     = 0;
	localparam int CONT_BIT       = 1;
	localparam int CLEAR_BIT      = 7;
	localparam int PIN_MODE_BIT   = 3;
	localparam int THRESH_BATT_LSB = 6;
	localparam int THRESH_DRV_LSB  = 0;

	// Reset values
	localparam logic [7:0] REG_RESET        = 8'h00;

	// Converter channel codes and colour slots
	localparam logic [1:0] CHAN_TEMP        = 2'h0;
	localparam logic [1:0] CHAN_BATT        = 2'h1;
	localparam logic [1:0] CHAN_OUT         = 2'h2;
	localparam logic [1:0] COLOUR_RED       = 2'h0;
	localparam logic [1:0] COLOUR_NONE      = 2'h3;

	// Temperature code of the overtemperature threshold (120 C)
	localparam logic [9:0] OVERTEMP_CODE    = 10'h2F0;

	// Timing
	localparam int CLK_MHZ          = 250;
	localparam int CONV_RATE_SPS    = 4000;
	localparam int CONV_PERIOD_CYC  = CLK_MHZ * 1000000 / CONV_RATE_SPS;
	localparam int SETTLE_US        = 500;
	localparam int SETTLE_CYC       = SETTLE_US * CLK_MHZ;
	localparam int FAIL_UNIT_US     = 100;
	localparam int FAIL_UNIT_CYC    = FAIL_UNIT_US * CLK_MHZ;
	localparam int TIMER_W          = 20;

	// Analog comparator and driver inputs
	typedef struct packed {
		logic [3:0] regulatorOn;
		logic [3:0] regulatorLow;
		logic [3:0] mirrorLow;
		logic [1:0] currentLimit;
		logic [3:0] batteryLow;
		logic       outputUnder;
		logic       outputOver;
		logic [2:0] driverOn;
		logic [2:0] driverLow;
	} mafa_alarm_in_t;

	// Every pin input that crosses into the clock domain
	typedef struct packed {
		mafa_alarm_in_t alarm;
		logic           modulation;
		logic           selB;
		logic           selA;
		logic           sda;
		logic           scl;
	} mafa_pins_t;

	// Converter request and answer
	typedef struct packed {
		logic       start;
		logic [1:0] channel;
	} mafa_adc_req_t;

	typedef struct packed {
		logic       done;
		logic [9:0] data;
	} mafa_adc_res_t;

	// Control levels to the analog side
	typedef struct packed {
		logic       projectionEnable;
		logic       emitterEnable;
		logic [1:0] batteryThreshold;
		logic [1:0] driverThreshold;
	} mafa_ctrl_t;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_ACK  = 3'b010,
		I_WR   = 3'b011,
		I_RD   = 3'b100,
		I_RACK = 3'b101
	} mafa_i2c_state_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_TEMP = 2'b01,
		S_BATT = 2'b10,
		S_OUT  = 2'b11
	} mafa_seq_t;

	// Whole state of the block
	typedef struct packed {
		mafa_pins_t            sync1;
		mafa_pins_t            sync2;
		mafa_pins_t            sync3;
		mafa_pins_t            filt;
		logic                  sclPrev;
		logic                  sdaPrev;
		mafa_i2c_state_t       i2cState;
		logic [3:0]            bitCnt;
		logic [7:0]            shiftReg;
		logic [7:0]            regPtr;
		logic                  isRead;
		logic                  havePtr;
		logic                  sdaOeN;
		logic                  projEnable;
		logic                  emitEnable;
		logic [7:0]            inputCfg;
		logic [7:0]            contCtrl;
		logic [7:0]            mask0;
		logic [7:0]            mask1;
		logic [7:0]            threshCfg;
		logic [3:0]            pinCfg;
		logic [7:0]            status0;
		logic [7:0]            status1;
		logic [15:0]           rawPrev;
		logic                  faultOeN;
		logic [TIMER_W-1:0]    pulseCnt;
		mafa_seq_t             seq;
		logic                  convBusy;
		logic                  convStart;
		logic [1:0]            convChan;
		logic [1:0]            colour;
		logic [TIMER_W-1:0]    seqTimer;
		logic [2:0]            subPrev;
		logic [9:0]            tempResult;
		logic [2:0][9:0]       battResult;
		logic [2:0][9:0]       outResult;
		logic [2:0]            convDone;
	} mafa_state_t;

endpackage

// ===== rtl/mafa_top.sv
// Monitor converter sequencer, fault alarm logic and two-wire register target
// Function
// - 10-bit 4 ksps converter shared by three inputs
// - Convert temperature, battery, output; store results
// - Select pins, plus modulation, define sub-frames
// - Output conversion starts 500 us after sub-frame
// - Per-colour voltage results, one temperature result
// - Continuous mode cycles, stores into red slots
// - Open-collector fault pin, status or pulse mode
// - Pulse ends on time, repeats on change
// - Alarm bits sticky until clear bit written
// - Each alarm bit has its own mask bit
// - Enabled regulator below 90% flags alarm
// - Mirror supplies low flag under both enables
// - Buck-boost current limits flag two bits
// - Overtemperature from converter, only with emitter enabled
// - Battery undervoltage, threshold from config bits
// - Converter output below 1.5 V flags
// - Converter output above 5.2 V flags
// - Per-channel driver low voltage, programmable threshold
// - Battery below 2.55 V resets every register
// - Thermal shutdown resets; host rewrites registers
// - Two-wire target at address 36h, 400 kHz
`timescale 1ns/10ps

module mafa_top #(
	parameter int CONV_PERIOD_CYCLES = mafa_pkg::CONV_PERIOD_CYC,
	parameter int SETTLE_CYCLES      = mafa_pkg::SETTLE_CYC,
	parameter int FAIL_UNIT_CYCLES   = mafa_pkg::FAIL_UNIT_CYC
) (
	// Clock and power or thermal reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	// Two-wire bus pins
	input  wire logic                    sclIn,
	input  wire logic                    sdaIn,
	output logic                         sdaOut,
	output logic                         sdaOeN,
	// Sub-frame pins
	input  wire logic                    subframeSelectA,
	input  wire logic                    subframeSelectB,
	input  wire logic                    modulationIn,
	// Analog comparators and driver state
	input  wire mafa_pkg::mafa_alarm_in_t alarmIn,
	// Monitor converter
	output mafa_pkg::mafa_adc_req_t      adcReq,
	input  wire mafa_pkg::mafa_adc_res_t adcRes,
	// Control levels
	output mafa_pkg::mafa_ctrl_t         ctrlOut,
	// Fault pin, open collector
	output logic                         faultOut,
	output logic                         faultOeN
);
	import mafa_pkg::*;

	mafa_state_t q;
	mafa_state_t d;

	// Register read multiplexer
	function automatic logic [7:0] readReg(input mafa_state_t s, input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] off;
		r = 8'h00;
		off = a - ADDR_COLOUR_HI;
		if (a >= ADDR_COLOUR_HI && a <= ADDR_COLOUR_END) begin
			r = off[0] ? s.outResult[off[2:1]][9:2] : s.battResult[off[2:1]][9:2];
		end else begin
			case (a)
				ADDR_PROJ_CTRL:   r = {7'h00, s.projEnable};
				ADDR_EMIT_CTRL:   r = {7'h00, s.emitEnable};
				ADDR_TEMP_HI:     r = s.tempResult[9:2];
				ADDR_TEMP_LO:     r = {6'h00, s.tempResult[1:0]};
				ADDR_BATT_LO: r = {2'h0, s.battResult[2][1:0], s.battResult[1][1:0],
					s.battResult[0][1:0]};
				ADDR_OUT_LO: r = {2'h0, s.outResult[2][1:0], s.outResult[1][1:0],
					s.outResult[0][1:0]};
				ADDR_INPUT_CFG:   r = s.inputCfg;
				ADDR_CONT_CTRL:   r = s.contCtrl;
				ADDR_CONV_STATUS: r = {5'h00, s.convDone};
				ADDR_PIN_CFG:     r = {4'h0, s.pinCfg};
				ADDR_STATUS0:     r = s.status0;
				ADDR_STATUS1:     r = s.status1;
				ADDR_MASK0:       r = s.mask0;
				ADDR_MASK1:       r = s.mask1;
				ADDR_THRESH:      r = s.threshCfg;
				default:          r = 8'h00;
			endcase
		end
		return r;
	endfunction

	// Next-state logic of the whole block
	always_comb begin
		logic        sclF;
		logic        sdaF;
		logic        sclRise;
		logic        sclFall;
		logic        startCond;
		logic        stopCond;
		logic        clearNow;
		logic [7:0]  rdByte;
		logic [7:0]  raw0;
		logic [7:0]  raw1;
		logic [15:0] unmasked;
		logic        pwmUsed;
		logic [2:0]  subNow;
		logic        contMode;
		logic        trigger;
		sclF      = q.filt.scl;
		sdaF      = q.filt.sda;
		sclRise   = sclF & ~q.sclPrev;
		sclFall   = ~sclF & q.sclPrev;
		startCond = sclF & q.sclPrev & q.sdaPrev & ~sdaF;
		stopCond  = sclF & q.sclPrev & ~q.sdaPrev & sdaF;
		clearNow  = 1'b0;
		rdByte    = readReg(q, q.regPtr);
		raw0      = 8'h00;
		raw1      = 8'h00;
		unmasked  = 16'h0000;
		pwmUsed   = 1'b0;
		subNow    = 3'h0;
		contMode  = 1'b0;
		trigger   = 1'b0;

		d = q;
		d.convStart = 1'b0;

		// Pin synchronisers: a change counts once stages two and three agree
		d.sync1 = mafa_pins_t'({subframeSelectB, subframeSelectA, sdaIn, sclIn} == 4'h0 ?
			{alarmIn, modulationIn, 4'h0} : {alarmIn, modulationIn, subframeSelectB,
			subframeSelectA, sdaIn, sclIn});
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		d.filt  = mafa_pins_t'((q.sync2 & q.sync3) | (q.filt & (q.sync2 ^ q.sync3)));
		d.sclPrev = sclF;
		d.sdaPrev = sdaF;

		// Two-wire target
		if (startCond) begin
			d.i2cState = I_ADDR;
			d.bitCnt   = 4'h0;
			d.havePtr  = 1'b0;
			d.sdaOeN   = 1'b1;
		end else if (stopCond) begin
			d.i2cState = I_IDLE;
			d.sdaOeN   = 1'b1;
		end else begin
			case (q.i2cState)
				I_ADDR, I_WR: begin
					if (sclRise) begin
						d.shiftReg = {q.shiftReg[6:0], sdaF};
						d.bitCnt   = q.bitCnt + 4'h1;
					end else if (sclFall && q.bitCnt == 4'h8) begin
						d.bitCnt = 4'h0;
						if (q.i2cState == I_ADDR) begin
							if (q.shiftReg[7:1] == TARGET_ADDR) begin
								d.isRead   = q.shiftReg[0];
								d.sdaOeN   = 1'b0;
								d.i2cState = I_ACK;
							end else begin
								d.i2cState = I_IDLE;
							end
						end else begin
							d.sdaOeN   = 1'b0;
							d.i2cState = I_ACK;
							if (!q.havePtr) begin
								d.regPtr  = q.shiftReg;
								d.havePtr = 1'b1;
							end else begin
								d.regPtr = q.regPtr + 8'h01;
								case (q.regPtr)
									ADDR_PROJ_CTRL:   d.projEnable = q.shiftReg[ENABLE_BIT];
									ADDR_EMIT_CTRL:   d.emitEnable = q.shiftReg[ENABLE_BIT];
									ADDR_INPUT_CFG:   d.inputCfg = q.shiftReg;
									ADDR_CONT_CTRL:   d.contCtrl = q.shiftReg;
									ADDR_FAULT_CLEAR: clearNow = q.shiftReg[CLEAR_BIT];
									ADDR_PIN_CFG:     d.pinCfg = q.shiftReg[3:0];
									ADDR_MASK0:       d.mask0 = q.shiftReg;
									ADDR_MASK1:       d.mask1 = q.shiftReg;
									ADDR_THRESH:      d.threshCfg = q.shiftReg;
									default:          d.threshCfg = q.threshCfg;
								endcase
							end
						end
					end
				end
				I_ACK: begin
					if (sclFall) begin
						if (q.isRead) begin
							d.shiftReg = rdByte;
							d.sdaOeN   = rdByte[7];
							d.regPtr   = q.regPtr + 8'h01;
							d.bitCnt   = 4'h1;
							d.i2cState = I_RD;
						end else begin
							d.sdaOeN   = 1'b1;
							d.i2cState = I_WR;
						end
					end
				end
				I_RD: begin
					if (sclFall) begin
						if (q.bitCnt == 4'h8) begin
							d.sdaOeN   = 1'b1;
							d.bitCnt   = 4'h0;
							d.i2cState = I_RACK;
						end else begin
							d.sdaOeN   = q.shiftReg[6];
							d.shiftReg = {q.shiftReg[6:0], 1'b0};
							d.bitCnt   = q.bitCnt + 4'h1;
						end
					end
				end
				I_RACK: begin
					// Host acknowledge continues the read, no acknowledge ends it
					if (sclRise) begin
						d.i2cState = sdaF ? I_IDLE : I_ACK;
					end
				end
				default: begin
					d.i2cState = I_IDLE;
					d.sdaOeN   = 1'b1;
				end
			endcase
		end

		// Raw alarm conditions
		raw0[3:0] = q.filt.alarm.regulatorOn & q.filt.alarm.regulatorLow;
		raw0[4]   = q.emitEnable & q.projEnable & (|q.filt.alarm.mirrorLow);
		raw0[6:5] = q.filt.alarm.currentLimit;
		raw0[7]   = q.emitEnable & (q.tempResult >= OVERTEMP_CODE);
		raw1[0]   = |q.filt.alarm.batteryLow;
		raw1[1]   = q.filt.alarm.outputUnder;
		raw1[4]   = q.filt.alarm.outputOver;
		raw1[7:5] = q.filt.alarm.driverOn & q.filt.alarm.driverLow;

		// Sticky capture, a new event wins over the clear
		d.status0 = (clearNow ? 8'h00 : q.status0) | raw0;
		d.status1 = (clearNow ? 8'h00 : q.status1) | raw1;
		d.rawPrev = {raw1, raw0};
		unmasked  = {raw1, raw0} & ~{q.mask1, q.mask0};

		// Fault pin: level in status mode, timed pulse in interrupt mode
		if (!q.pinCfg[PIN_MODE_BIT]) begin
			d.faultOeN = ~|unmasked;
			d.pulseCnt = '0;
		end else if (|(({raw1, raw0} ^ q.rawPrev) & ~{q.mask1, q.mask0})) begin
			d.faultOeN = 1'b0;
			d.pulseCnt = TIMER_W'((32'(q.pinCfg[2:0]) + 32'd1) * 32'(FAIL_UNIT_CYCLES));
		end else if (q.pulseCnt > TIMER_W'(1)) begin
			d.pulseCnt = q.pulseCnt - TIMER_W'(1);
		end else begin
			d.faultOeN = 1'b1;
			d.pulseCnt = '0;
		end

		// Sub-frame detection
		pwmUsed = (q.inputCfg[1:0] == 2'b11) | (q.inputCfg[3:2] == 2'b11) |
			(q.inputCfg[5:4] == 2'b11);
		subNow   = {q.filt.modulation & pwmUsed, q.filt.selB, q.filt.selA};
		d.subPrev = subNow;
		contMode = q.contCtrl[CONT_BIT];
		trigger  = contMode ? (q.seq == S_IDLE) : (subNow != q.subPrev);

		// Converter sequence: temperature, battery, then output after settling
		if (q.seq != S_IDLE && q.seqTimer != {TIMER_W{1'b1}}) begin
			d.seqTimer = q.seqTimer + TIMER_W'(1);
		end
		if (trigger) begin
			d.seq      = S_TEMP;
			d.seqTimer = '0;
			d.convBusy = 1'b0;
			d.colour   = contMode ? COLOUR_RED : {q.filt.selB, q.filt.selA};
			if (!contMode && {q.filt.selB, q.filt.selA} != COLOUR_NONE) begin
				d.convDone[{q.filt.selB, q.filt.selA}] = 1'b0;
			end
		end else begin
			case (q.seq)
				S_TEMP: begin
					if (!q.convBusy) begin
						d.convStart = 1'b1;
						d.convChan  = CHAN_TEMP;
						d.convBusy  = 1'b1;
					end else if (adcRes.done) begin
						d.tempResult = adcRes.data;
						d.convBusy   = 1'b0;
						d.seq        = S_BATT;
					end
				end
				S_BATT: begin
					if (!q.convBusy && q.seqTimer >= TIMER_W'(CONV_PERIOD_CYCLES)) begin
						d.convStart = 1'b1;
						d.convChan  = CHAN_BATT;
						d.convBusy  = 1'b1;
					end else if (q.convBusy && adcRes.done) begin
						if (q.colour != COLOUR_NONE) begin
							d.battResult[q.colour] = adcRes.data;
						end
						d.convBusy = 1'b0;
						d.seq      = S_OUT;
					end
				end
				S_OUT: begin
					if (!q.convBusy && q.seqTimer >= TIMER_W'(SETTLE_CYCLES)) begin
						d.convStart = 1'b1;
						d.convChan  = CHAN_OUT;
						d.convBusy  = 1'b1;
					end else if (q.convBusy && adcRes.done) begin
						if (q.colour != COLOUR_NONE) begin
							d.outResult[q.colour] = adcRes.data;
							d.convDone[q.colour]  = 1'b1;
						end
						d.convBusy = 1'b0;
						d.seq      = S_IDLE;
					end
				end
				default: begin
					d.convBusy = 1'b0;
				end
			endcase
		end
	end

	// State register; the reset input is the supply and thermal reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			q          <= '0;
			q.sdaOeN   <= 1'b1;
			q.faultOeN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign sdaOut   = q.convBusy & 1'b0;
	assign sdaOeN   = q.sdaOeN;
	assign faultOut = q.convBusy & 1'b0;
	assign faultOeN = q.faultOeN;
	assign adcReq   = '{start: q.convStart, channel: q.convChan};
	assign ctrlOut  = '{projectionEnable: q.projEnable, emitterEnable: q.emitEnable,
		batteryThreshold: q.threshCfg[THRESH_BATT_LSB +: 2],
		driverThreshold: q.threshCfg[THRESH_DRV_LSB +: 2]};

endmodule

// ===== bench/mafa_chk.sv
// Checker of converter order, bus timing and reset levels
`timescale 1ns/10ps

module mafa_chk
	import mafa_pkg::*;
#(
	parameter int CONV_PERIOD_CYCLES = 20,
	parameter int SETTLE_CYCLES      = 40,
	parameter int FAIL_UNIT_CYCLES   = 5
) (
	// Clock and reset
	input wire logic                     clk_sys,
	input wire logic                     reset,
	// Bus and sub-frame pins
	input wire logic                     sclIn,
	input wire logic                     sdaIn,
	input wire logic                     sdaOut,
	input wire logic                     sdaOeN,
	input wire logic                     subframeSelectA,
	input wire logic                     subframeSelectB,
	input wire logic                     modulationIn,
	// Alarms, converter, control and fault pin
	input wire mafa_pkg::mafa_alarm_in_t alarmIn,
	input wire mafa_pkg::mafa_adc_req_t  adcReq,
	input wire mafa_pkg::mafa_adc_res_t  adcRes,
	input wire mafa_pkg::mafa_ctrl_t     ctrlOut,
	input wire logic                     faultOut,
	input wire logic                     faultOeN
);
	logic [1:0]  lastChan_q;
	logic [19:0] seqCnt_q;

	// Last channel started, cycles since the temperature start
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			lastChan_q <= 2'h3;
			seqCnt_q   <= 20'h0_0000;
		end else begin
			if (adcReq.start)
				lastChan_q <= adcReq.channel;
			if (adcReq.start && adcReq.channel == CHAN_TEMP)
				seqCnt_q <= 20'h0_0000;
			else if (seqCnt_q != 20'hF_FFFF)
				seqCnt_q <= seqCnt_q + 20'h0_0001;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_start_pulse: assert property (adcReq.start |=> !adcReq.start)
		else $error("converter start longer than one cycle");
	a_chan_legal: assert property (adcReq.start |-> adcReq.channel != 2'h3)
		else $error("converter started on unused channel");
	a_chan_hold: assert property ($changed(adcReq.channel) |-> adcReq.start)
		else $error("channel moved without a start");
	a_batt_after_temp: assert property (adcReq.start && adcReq.channel == CHAN_BATT
		|-> lastChan_q == CHAN_TEMP && seqCnt_q >= CONV_PERIOD_CYCLES - 1)
		else $error("battery conversion out of order or early");
	a_out_settled: assert property (adcReq.start && adcReq.channel == CHAN_OUT
		|-> lastChan_q == CHAN_BATT && seqCnt_q >= SETTLE_CYCLES - 1)
		else $error("output conversion before settling time");
	a_sda_scl_low: assert property ($fell(sdaOeN) |-> !sclIn && !$past(sclIn))
		else $error("data line pulled while bus clock high");
	a_pins_open_drain: assert property (sdaOut == 1'b0 && faultOut == 1'b0)
		else $error("open drain pin driven high");
	a_ctrl_on_write: assert property ($changed(ctrlOut) |-> !sclIn)
		else $error("control levels moved outside a bus write");
	a_reset_quiet: assert property (disable iff (1'b0) reset |-> sdaOeN && faultOeN
		&& !adcReq.start && ctrlOut == '0)
		else $error("outputs active during reset");

	// Main scenarios reached
	c_out_conv: cover property (adcReq.start && adcReq.channel == CHAN_OUT);
	c_fault_low: cover property ($fell(faultOeN));
	c_target_ack: cover property ($fell(sdaOeN));
endmodule

bind mafa_top mafa_chk #(.CONV_PERIOD_CYCLES(CONV_PERIOD_CYCLES),
	.SETTLE_CYCLES(SETTLE_CYCLES), .FAIL_UNIT_CYCLES(FAIL_UNIT_CYCLES)) mafa_chk_inst (
	.clk_sys(clk_sys), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOeN(sdaOeN), .subframeSelectA(subframeSelectA), .subframeSelectB(subframeSelectB),
	.modulationIn(modulationIn), .alarmIn(alarmIn), .adcReq(adcReq), .adcRes(adcRes),
	.ctrlOut(ctrlOut), .faultOut(faultOut), .faultOeN(faultOeN));

// ===== bench/mafa_host_model.sv
// Host model: two-wire bus controller reaching the register target
`timescale 1ns/10ps

module mafa_host_model
	import mafa_pkg::*;
(
	// Clock and resolved data line
	input  wire logic clk_sys,
	input  wire logic sdaLevel,
	// Bus lines, one means released
	output logic      scl,
	output logic      sdaRel
);
	// Bus idles released
	initial begin
		scl = 1'b1;
		sdaRel = 1'b1;
	end

	// Quarter bus period, three clocks: a 48 ns bus clock
	task automatic qtr();
		repeat (3) @(negedge clk_sys);
	endtask

	// Start or repeated start
	task automatic start_cond();
		sdaRel = 1'b1;
		qtr();
		scl = 1'b1;
		qtr();
		sdaRel = 1'b0;
		qtr();
		scl = 1'b0;
		qtr();
	endtask

	// Stop, data rises while clock high
	task automatic stop_cond();
		sdaRel = 1'b0;
		qtr();
		scl = 1'b1;
		qtr();
		sdaRel = 1'b1;
		qtr();
	endtask

	// One bit, data held over the whole high phase
	task automatic bit_io(input logic b, output logic r);
		sdaRel = b;
		qtr();
		scl = 1'b1;
		qtr();
		r = sdaLevel;
		qtr();
		scl = 1'b0;
		qtr();
	endtask

	// Byte out, returns one when not acknowledged
	task automatic put(input logic [7:0] d, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, nak);
	endtask

	// Byte in, host acknowledge unless last
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask

	// Register write: address, pointer, data
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic n0, n1, n2;
		start_cond();
		put({TARGET_ADDR, 1'b0}, n0);
		put(p, n1);
		put(d, n2);
		stop_cond();
		ok = !(n0 | n1 | n2);
	endtask

	// Register read: pointer, repeated start, one byte
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic n;
		start_cond();
		put({TARGET_ADDR, 1'b0}, n);
		put(p, n);
		start_cond();
		put({TARGET_ADDR, 1'b1}, n);
		get(1'b1, d);
		stop_cond();
	endtask
endmodule

// ===== bench/mafa_top_tb.sv
// Self-checking testbench of the monitor converter and fault alarm block
`timescale 1ns/10ps

module mafa_top_tb;
	import mafa_pkg::*;
	localparam int PER = 20;
	localparam int SET = 40;
	localparam int UNIT = 5;
	localparam logic [7:0] RL [6] = '{ADDR_STATUS0, ADDR_STATUS1, ADDR_MASK0, ADDR_MASK1,
		ADDR_PIN_CFG, 8'h7F};
	logic           clk_sys = 1'b0;
	logic           reset = 1'b0;
	logic           selA = 1'b0;
	logic           selB = 1'b0;
	logic           modIn = 1'b0;
	mafa_alarm_in_t alarmIn = '0;
	mafa_adc_res_t  adcRes = '0;
	mafa_adc_req_t  adcReq;
	mafa_ctrl_t     ctrlOut;
	logic           sdaOut, sdaOeN, faultOut, faultOeN, scl, sdaRel, sdaLevel, ok;
	logic [9:0]     adcVal [3];
	logic [7:0]     rdv, t;
	logic [15:0]    expS;
	int             adcWait = 0, bad_count = 0, checks = 0, cycles = 0, n, seed = 61699;

	// Open-drain data line with pull-up
	assign sdaLevel = sdaRel & (sdaOeN | sdaOut);

	mafa_top #(.CONV_PERIOD_CYCLES(PER), .SETTLE_CYCLES(SET), .FAIL_UNIT_CYCLES(UNIT))
	mafa_top_inst (.clk_sys(clk_sys), .reset(reset), .sclIn(scl), .sdaIn(sdaLevel),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .subframeSelectA(selA), .subframeSelectB(selB),
		.modulationIn(modIn), .alarmIn(alarmIn), .adcReq(adcReq), .adcRes(adcRes),
		.ctrlOut(ctrlOut), .faultOut(faultOut), .faultOeN(faultOeN));

	mafa_host_model hostInst (.clk_sys(clk_sys), .sdaLevel(sdaLevel), .scl(scl),
		.sdaRel(sdaRel));

	// Clock
	always #2 clk_sys = ~clk_sys;

	// Converter model: done four cycles after start
	always @(negedge clk_sys) begin
		if (adcReq.start)
			adcWait = 5;
		else if (adcWait > 0)
			adcWait = adcWait - 1;
		adcRes = {!adcReq.start && adcWait == 1, adcVal[adcReq.channel]};
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 80000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] p, input logic [7:0] d);
		hostInst.wr(p, d, ok);
		check(16'(ok), 16'h0001);
	endtask

	task automatic rchk(input logic [7:0] p, input logic [7:0] e);
		hostInst.rd(p, rdv);
		check(16'(rdv), 16'(e));
	endtask

	// Poll conversion status until the colour bit sets
	task automatic wait_conv(input logic [7:0] b);
		rdv = 8'h00;
		for (int i = 0; i < 8 && (rdv & b) == 8'h00; i++)
			hostInst.rd(ADDR_CONV_STATUS, rdv);
		check(16'(rdv & b), 16'(b));
	endtask

	// Status bits expected from alarm inputs, enables and temperature
	function automatic logic [15:0] exp_alarm(mafa_alarm_in_t a, logic pe, logic ee,
		logic [9:0] tp);
		logic [7:0] s0, s1;
		s0 = {ee && tp >= OVERTEMP_CODE, a.currentLimit, pe && ee && |a.mirrorLow,
			a.regulatorOn & a.regulatorLow};
		s1 = {a.driverOn & a.driverLow, a.outputOver, 2'b00, a.outputUnder, |a.batteryLow};
		return {s1, s0};
	endfunction

	initial begin
		#1 reset = 1'b1; // Clean reset edge ahead of the first clock edge
		foreach (adcVal[i])
			adcVal[i] = 10'h000;
		repeat (6) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		foreach (RL[i])
			rchk(RL[i], REG_RESET);
		hostInst.start_cond();
		hostInst.put({TARGET_ADDR ^ 7'h01, 1'b0}, ok);
		hostInst.stop_cond();
		check(16'(ok), 16'h0001);
		$display("test reset and address done");
		// Masks, thresholds and enables
		t = 8'($random(seed));
		wreg(ADDR_MASK0, t);
		rchk(ADDR_MASK0, t);
		wreg(ADDR_THRESH, t);
		wreg(ADDR_PROJ_CTRL, 8'h01);
		wreg(ADDR_EMIT_CTRL, 8'h01);
		check(16'(ctrlOut), 16'({2'b11, t[7:6], t[1:0]}));
		wreg(ADDR_MASK0, 8'h00);
		$display("test registers done");
		// Green sub-frame, temperature at the overtemperature boundary
		adcVal[0] = OVERTEMP_CODE;
		adcVal[1] = 10'($random(seed));
		adcVal[2] = 10'($random(seed));
		selA = 1'b1;
		wait_conv(8'h02);
		rchk(ADDR_TEMP_HI, adcVal[0][9:2]);
		rchk(ADDR_TEMP_LO, {6'h00, adcVal[0][1:0]});
		rchk(ADDR_COLOUR_HI + 8'h02, adcVal[1][9:2]);
		rchk(ADDR_COLOUR_HI + 8'h03, adcVal[2][9:2]);
		rchk(ADDR_BATT_LO, {4'h0, adcVal[1][1:0], 2'h0});
		rchk(ADDR_OUT_LO, {4'h0, adcVal[2][1:0], 2'h0});
		rchk(ADDR_STATUS0, 8'h80);
		$display("test sub-frame conversion done");
		// Continuous mode stores into red slots while pins say green
		adcVal[0] = 10'h100;
		wreg(ADDR_CONT_CTRL, 8'h02);
		wait_conv(8'h01);
		rchk(ADDR_COLOUR_HI, adcVal[1][9:2]);
		wreg(ADDR_CONT_CTRL, 8'h00);
		// Modulation pin counts only once an input pair reads 11b
		adcVal[0] = 10'h155;
		modIn = 1'b1;
		rchk(ADDR_TEMP_HI, 8'h40);
		wreg(ADDR_INPUT_CFG, 8'h03);
		rchk(ADDR_TEMP_HI, adcVal[0][9:2]);
		modIn = 1'b0;
		$display("test continuous mode done");
		// Alarm capture, pin in status mode, stickiness after removal
		for (int k = 0; k < 4; k++) begin
			alarmIn = '0;
			wreg(ADDR_FAULT_CLEAR, 8'h80);
			alarmIn = (k == 0) ? '1 : mafa_alarm_in_t'($random(seed));
			expS = exp_alarm(alarmIn, 1'b1, 1'b1, adcVal[0]);
			repeat (8) @(negedge clk_sys);
			check(16'(faultOeN), 16'(expS == 16'h0000));
			alarmIn = '0;
			rchk(ADDR_STATUS0, expS[7:0]);
			rchk(ADDR_STATUS1, expS[15:8]);
			check(16'(faultOeN), 16'h0001);
		end
		$display("test alarms done");
		// Masked alarm captured without pin, then pulse mode
		wreg(ADDR_FAULT_CLEAR, 8'h80);
		wreg(ADDR_MASK1, 8'h10);
		alarmIn.outputOver = 1'b1;
		repeat (8) @(negedge clk_sys);
		check(16'(faultOeN), 16'h0001);
		rchk(ADDR_STATUS1, 8'h10);
		t = 8'($random(seed)) & 8'h07;
		wreg(ADDR_PIN_CFG, 8'h08 | t);
		for (int e = 0; e < 2; e++) begin
			alarmIn.outputUnder = (e == 0);
			n = 0;
			for (int i = 0; i < 12 && faultOeN !== 1'b0; i++)
				@(negedge clk_sys);
			while (faultOeN === 1'b0 && n < 100) begin
				n++;
				@(negedge clk_sys);
			end
			check(16'(n), 16'((t + 1) * UNIT));
			repeat (20) @(negedge clk_sys);
			check(16'(faultOeN), 16'h0001);
		end
		$display("test pulse mode done");
		// Second reset in mid-run
		alarmIn = '0;
		reset = 1'b1;
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		repeat (10) @(negedge clk_sys);
		rchk(ADDR_MASK1, REG_RESET);
		rchk(ADDR_PIN_CFG, REG_RESET);
		$display("test second reset done");
		close_out();
	end
endmodule
